// >>> table_access_unit.sv
// Table access unit: moves bytes or words between program memory and the core.
// Assumes a core that holds a request until done, and a program memory that
// answers each enable with a one-cycle acknowledge.
//
// Summary of operation
// R1 - Low ops reach lower program word directly
// R2 - Only high ops touch the upper byte
// R3 - Program word step of two addresses
// R4 - Low and high spaces share address range
// R5 - Every op has byte and word mode
// R6 - Low word read copies bits 15..0
// R7 - Low byte read selects byte by select
// R8 - High word read gives 23..16, upper zero
// R9 - High byte read: phantom byte gives zero
// R10 - Writes mirror the read lane mapping
// R11 - Page register supplies every access region
// R12 - Page bit 7 selects configuration space
// R13 - Address is page concatenated with address
//
// Chosen here: the Avalon-MM register port and the register addresses.
module table_access_unit (
  input wire logic sys_clk,
  input wire logic reset,
  // Core side
  input wire logic tbl_start,
  input wire logic [1:0] tbl_op,
  input wire logic tbl_byte_mode,
  input wire logic [table_access_pkg::EA_W-1:0] tbl_ea,
  input wire logic [table_access_pkg::DATA_W-1:0] tbl_wdata,
  output logic tbl_busy,
  output logic tbl_done,
  output logic [table_access_pkg::DATA_W-1:0] tbl_rdata,
  // Program memory side
  output logic pm_en,
  output logic pm_we,
  output logic pm_cfg_space,
  output logic [table_access_pkg::PADDR_W-1:0] pm_addr,
  output logic [table_access_pkg::PWORD_W-1:0] pm_wdata,
  output logic [table_access_pkg::LANES-1:0] pm_wmask,
  input wire logic [table_access_pkg::PWORD_W-1:0] pm_rdata,
  input wire logic pm_ack,
  // Avalon-MM register slave
  input wire logic [table_access_pkg::BUS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [table_access_pkg::BUS_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [table_access_pkg::BUS_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  table_access_pkg::seq_state_e state_r;
  table_access_pkg::seq_state_e state_nxt;
  logic [table_access_pkg::PAGE_W-1:0] table_page_reg_r;
  logic [table_access_pkg::PADDR_W-1:0] last_addr_r;
  logic [table_access_pkg::COUNT_W-1:0] op_count_r;
  logic [1:0] op_r;
  logic byte_mode_r;
  logic byte_sel_r;
  logic [table_access_pkg::DATA_W-1:0] wdata_r;
  logic busy_r;
  logic done_r;
  logic [table_access_pkg::DATA_W-1:0] rdata_r;
  logic pm_en_r;
  logic pm_we_r;
  logic cfg_r;
  logic [table_access_pkg::PADDR_W-1:0] pm_addr_r;
  logic [table_access_pkg::PWORD_W-1:0] pm_wdata_r;
  logic [table_access_pkg::LANES-1:0] pm_wmask_r;
  logic [table_access_pkg::BUS_DATA_W-1:0] readdata_r;
  logic wait_r;
  logic [table_access_pkg::DATA_W-1:0] fmt_rdata;
  logic [table_access_pkg::PWORD_W-1:0] fmt_wword;
  logic [table_access_pkg::LANES-1:0] fmt_wmask;
  logic bus_req;
  logic bus_accept;
  logic [table_access_pkg::BUS_DATA_W-1:0] status_word;
  logic start_take;

  assign start_take = (state_r == table_access_pkg::ST_IDLE) && tbl_start;
  assign bus_req = avs_read || avs_write;
  assign bus_accept = bus_req && !wait_r;

  // ----------------------------------------------------------------
  // Lane formatting
  // ----------------------------------------------------------------
  // Both lane modules see the latched op, so core inputs may move after take
  table_read_lanes #(
    .PW(table_access_pkg::PWORD_W),
    .DW(table_access_pkg::DATA_W)
  ) u_read_lanes (
    .high_space(op_r[0]),
    .byte_mode(byte_mode_r),
    .byte_sel(byte_sel_r),
    .pword(pm_rdata),
    .rdata(fmt_rdata)
  );

  table_write_lanes #(
    .PW(table_access_pkg::PWORD_W),
    .DW(table_access_pkg::DATA_W)
  ) u_write_lanes (
    .high_space(op_r[0]),
    .byte_mode(byte_mode_r),
    .byte_sel(byte_sel_r),
    .wdata(wdata_r),
    .pword(fmt_wword),
    .lane_mask(fmt_wmask)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state; one memory access per table op
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      table_access_pkg::ST_IDLE: begin
        if (tbl_start) begin
          state_nxt = table_access_pkg::ST_ISSUE;
        end
      end
      table_access_pkg::ST_ISSUE: begin
        state_nxt = table_access_pkg::ST_WAIT;
      end
      table_access_pkg::ST_WAIT: begin
        if (pm_ack) begin
          state_nxt = table_access_pkg::ST_DONE;
        end
      end
      table_access_pkg::ST_DONE: begin
        state_nxt = table_access_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= table_access_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Latch the request; the byte select is the address lsb
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      op_r <= table_access_pkg::OP_READ_LOW;
      byte_mode_r <= 1'b0;
      byte_sel_r <= 1'b0;
      wdata_r <= '0;
    end else if (start_take) begin
      op_r <= tbl_op; // R5
      byte_mode_r <= tbl_byte_mode; // R5
      byte_sel_r <= tbl_ea[0];
      wdata_r <= tbl_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Program memory port
  // ----------------------------------------------------------------
  // Page captured at take, so a page write mid-op cannot split an address
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pm_addr_r <= '0;
      cfg_r <= 1'b0;
    end else if (start_take) begin
      // Word address: ea lsb dropped, one program word per two addresses
      pm_addr_r <= {table_page_reg_r, tbl_ea[table_access_pkg::EA_W-1:1], 1'b0}; // R13 R11 R3 R4 R1
      cfg_r <= table_page_reg_r[table_access_pkg::PAGE_CFG_BIT]; // R12
    end
  end

  // Enable pulses one cycle after issue, once the op is latched, so that
  // direction, data and lane mask stand together with it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pm_en_r <= 1'b0;
      pm_we_r <= 1'b0;
      pm_wdata_r <= '0;
      pm_wmask_r <= table_access_pkg::MASK_NONE;
    end else begin
      pm_en_r <= state_r == table_access_pkg::ST_ISSUE; // R1
      pm_we_r <= (state_r == table_access_pkg::ST_ISSUE) && op_r[1];
      if (state_r == table_access_pkg::ST_ISSUE && op_r[1]) begin
        pm_wdata_r <= fmt_wword; // R10
        pm_wmask_r <= fmt_wmask; // R10 R2
      end
    end
  end

  // ----------------------------------------------------------------
  // Core answer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      busy_r <= state_nxt != table_access_pkg::ST_IDLE;
      done_r <= (state_r == table_access_pkg::ST_WAIT) && pm_ack;
      if (state_r == table_access_pkg::ST_WAIT && pm_ack && !op_r[1]) begin
        rdata_r <= fmt_rdata; // R6 R7 R8 R9
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Page register, byte lane 0 only; upper bus bits ignored
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      table_page_reg_r <= table_access_pkg::PAGE_RESET;
    end else if (bus_accept && avs_write && avs_address == table_access_pkg::OFS_TABLE_PAGE
                 && avs_byteenable[0]) begin
      table_page_reg_r <= avs_writedata[table_access_pkg::PAGE_W-1:0]; // R11
    end
  end

  // Trace of the last access and a running op count for software
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      last_addr_r <= '0;
      op_count_r <= '0;
    end else if (state_r == table_access_pkg::ST_WAIT && pm_ack) begin
      last_addr_r <= pm_addr_r | {{(table_access_pkg::PADDR_W-1){1'b0}}, byte_sel_r};
      op_count_r <= op_count_r + 1'b1;
    end
  end

  always_comb begin
    status_word = '0;
    status_word[table_access_pkg::STAT_BUSY_BIT] = busy_r;
    status_word[table_access_pkg::STAT_CFG_BIT] = cfg_r;
    status_word[table_access_pkg::STAT_OP_LSB +: 2] = op_r;
    status_word[table_access_pkg::STAT_BYTE_BIT] = byte_mode_r;
  end

  // Waitrequest drops for one cycle per request; unmapped reads return zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wait_r <= 1'b1;
      readdata_r <= '0;
    end else begin
      wait_r <= !(bus_req && wait_r);
      if (avs_read && wait_r) begin
        unique case (avs_address)
          table_access_pkg::OFS_TABLE_PAGE: readdata_r <= {24'h000000, table_page_reg_r};
          table_access_pkg::OFS_STATUS: readdata_r <= status_word;
          table_access_pkg::OFS_LAST_ADDR: readdata_r <= {8'h00, last_addr_r};
          table_access_pkg::OFS_OP_COUNT: readdata_r <= {16'h0000, op_count_r};
          default: readdata_r <= '0;
        endcase
      end
    end
  end

  assign tbl_busy = busy_r;
  assign tbl_done = done_r;
  assign tbl_rdata = rdata_r;
  assign pm_en = pm_en_r;
  assign pm_we = pm_we_r;
  assign pm_cfg_space = cfg_r;
  assign pm_addr = pm_addr_r;
  assign pm_wdata = pm_wdata_r;
  assign pm_wmask = pm_wmask_r;
  assign avs_readdata = readdata_r;
  assign avs_waitrequest = wait_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_addr_from_page: assert property (start_take |=> pm_addr == {$past(table_page_reg_r), $past(tbl_ea[15:1]), 1'b0}) // R13
    else $error("program address not page plus address");
  chk_cfg_space_bit: assert property (start_take |=> pm_cfg_space == $past(table_page_reg_r[7])) // R12
    else $error("config space flag does not follow page bit 7");
  chk_word_step_two: assert property (pm_en |-> pm_addr[0] == 1'b0) // R3
    else $error("program word address is odd");
  chk_en_one_pulse: assert property (start_take |=> ##1 pm_en ##1 !pm_en) // R1
    else $error("memory enable not a single pulse");
  chk_high_read_zero: assert property (done_r && !op_r[1] && op_r[0] |-> tbl_rdata[15:8] == 8'h00) // R8
    else $error("high read upper byte not zero");
  chk_phantom_byte_zero: assert property (done_r && op_r == 2'h1 && byte_mode_r && byte_sel_r |-> tbl_rdata == '0) // R9
    else $error("phantom byte read not zero");
  chk_low_word_copy: assert property (state_r == table_access_pkg::ST_WAIT && pm_ack && op_r == 2'h0
    && !byte_mode_r |=> tbl_rdata == $past(pm_rdata[15:0])) // R6
    else $error("low word read not copied");
  chk_low_byte_pick: assert property (state_r == table_access_pkg::ST_WAIT && pm_ack && op_r == 2'h0
    && byte_mode_r |=> tbl_rdata == {8'h00, $past(byte_sel_r) ? $past(pm_rdata[15:8]) : $past(pm_rdata[7:0])}) // R7
    else $error("low byte read wrong lane");
  chk_low_write_lanes: assert property (pm_we && op_r == 2'h2 |-> !pm_wmask[2]) // R2
    else $error("low write touches upper byte");
  chk_high_write_lanes: assert property (pm_we && op_r[0] |-> pm_wmask[1:0] == 2'h0) // R10
    else $error("high write touches lower word");
  chk_mode_latched: assert property (start_take |=> byte_mode_r == $past(tbl_byte_mode)) // R5
    else $error("byte mode not latched");
  chk_page_write: assert property (bus_accept && avs_write && avs_address == 4'h0 && avs_byteenable[0]
    |=> table_page_reg_r == $past(avs_writedata[7:0])) // R11
    else $error("page register write lost");
  chk_bus_one_wait: assert property (bus_req && wait_r |=> !wait_r ##1 wait_r) // R4
    else $error("bus answer timing wrong");
  chk_high_write_data: assert property (pm_we && pm_wmask[2] |-> pm_wdata[23:16] == wdata_r[7:0]) // R2
    else $error("high write data not in upper byte");

  cov_read_low: cover property (done_r && op_r == 2'h0);
  cov_read_high_byte: cover property (done_r && op_r == 2'h1 && byte_mode_r);
  cov_write_high: cover property (done_r && op_r == 2'h3);
  cov_cfg_access: cover property (done_r && cfg_r);

endmodule

// >>> table_access_pkg.sv
// Shared constants for the program space table access datapath.
// Assumes a 250 MHz core clock and an Avalon-MM register bus with 32-bit data.
package table_access_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PAGE_W = 8;
  localparam int EA_W = 16;
  localparam int PWORD_W = 24;
  localparam int DATA_W = 16;
  localparam int PADDR_W = PAGE_W + EA_W;
  localparam int BUS_ADDR_W = 4;
  localparam int BUS_DATA_W = 32;
  localparam int LANES = 3;

  // ----------------------------------------------------------------
  // Register byte addresses (one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [BUS_ADDR_W-1:0] OFS_TABLE_PAGE = 4'h0;
  localparam logic [BUS_ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [BUS_ADDR_W-1:0] OFS_LAST_ADDR = 4'h8;
  localparam logic [BUS_ADDR_W-1:0] OFS_OP_COUNT = 4'hc;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int PAGE_CFG_BIT = 7;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CFG_BIT = 1;
  localparam int STAT_OP_LSB = 2;
  localparam int STAT_BYTE_BIT = 4;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 8'h00;
  localparam int COUNT_W = 16;
  localparam logic [LANES-1:0] MASK_LOW_WORD = 3'h3;
  localparam logic [LANES-1:0] MASK_LOW_BYTE0 = 3'h1;
  localparam logic [LANES-1:0] MASK_LOW_BYTE1 = 3'h2;
  localparam logic [LANES-1:0] MASK_HIGH = 3'h4;
  localparam logic [LANES-1:0] MASK_NONE = 3'h0;

  // ----------------------------------------------------------------
  // Table operations: bit 1 = write, bit 0 = high space
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_READ_LOW = 2'h0,
    OP_READ_HIGH = 2'h1,
    OP_WRITE_LOW = 2'h2,
    OP_WRITE_HIGH = 2'h3
  } table_op_e;

  // Sequencer states, Gray along idle-issue-wait-done
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ISSUE = 2'h1,
    ST_WAIT = 2'h3,
    ST_DONE = 2'h2
  } seq_state_e;

endpackage

// >>> table_read_lanes.sv
// Read lane formatter: picks data bits out of a 24-bit program word.
// Assumes purely combinational use inside the table access sequencer.
module table_read_lanes #(
  parameter int PW = 24,
  parameter int DW = 16
) (
  input wire logic high_space,
  input wire logic byte_mode,
  input wire logic byte_sel,
  input wire logic [PW-1:0] pword,
  output logic [DW-1:0] rdata
);

  // ----------------------------------------------------------------
  // Lane selection
  // ----------------------------------------------------------------
  // Phantom byte of the high space always reads as zero
  always_comb begin
    rdata = '0;
    if (!high_space && !byte_mode) begin
      rdata = pword[DW-1:0]; // R6
    end else if (!high_space) begin
      rdata[7:0] = byte_sel ? pword[15:8] : pword[7:0]; // R7
    end else if (!byte_mode) begin
      rdata[7:0] = pword[PW-1:DW]; // R8
    end else if (!byte_sel) begin
      rdata[7:0] = pword[PW-1:DW]; // R9
    end
    // No clock here, so checked on the settled value of this process
    chk_high_upper_zero: assert (!high_space || rdata[DW-1:8] == '0) // R8
      else $error("high space read drives upper data byte");
  end

endmodule

// >>> table_write_lanes.sv
// Write lane mapper: places data into a 24-bit program word with lane mask.
// Assumes purely combinational use inside the table access sequencer.
module table_write_lanes #(
  parameter int PW = 24,
  parameter int DW = 16
) (
  input wire logic high_space,
  input wire logic byte_mode,
  input wire logic byte_sel,
  input wire logic [DW-1:0] wdata,
  output logic [PW-1:0] pword,
  output logic [2:0] lane_mask
);

  // ----------------------------------------------------------------
  // Lane mapping, the mirror of the read formatter
  // ----------------------------------------------------------------
  // A byte write to the phantom byte touches no lane at all
  always_comb begin
    pword = '0;
    lane_mask = table_access_pkg::MASK_NONE;
    if (!high_space && !byte_mode) begin
      pword[DW-1:0] = wdata; // R10
      lane_mask = table_access_pkg::MASK_LOW_WORD;
    end else if (!high_space) begin
      pword[15:8] = wdata[7:0];
      pword[7:0] = wdata[7:0];
      lane_mask = byte_sel ? table_access_pkg::MASK_LOW_BYTE1 : table_access_pkg::MASK_LOW_BYTE0; // R10
    end else if (!byte_mode || !byte_sel) begin
      pword[PW-1:DW] = wdata[7:0]; // R2
      lane_mask = table_access_pkg::MASK_HIGH;
    end
  end

endmodule

// >>> program_memory_model.sv
// Program memory model: answers each access after a delay chosen by the bench.
// Assumes one access in flight at a time, as the table unit promises.
module program_memory_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic pm_en,
  input wire logic pm_we,
  input wire logic pm_cfg_space,
  input wire logic [23:0] pm_addr,
  input wire logic [23:0] pm_wdata,
  input wire logic [2:0] pm_wmask,
  input wire logic [2:0] ack_delay,
  output logic [23:0] pm_rdata,
  output logic pm_ack,
  output logic [23:0] seen_addr,
  output logic [23:0] seen_wdata,
  output logic [2:0] seen_wmask,
  output logic seen_we,
  output logic seen_cfg,
  output logic [15:0] seen_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pending_r;
  logic [2:0] wait_r;

  // ----------------------------------------------------------------
  // Contents: a pattern of the address, so every location differs
  // ----------------------------------------------------------------
  function automatic logic [23:0] word_at(input logic [23:0] a);
    return {a[7:0] ^ a[23:16], a[15:0] ^ 16'h3c5a};
  endfunction

  // Capture each access and answer it later
  // Read bus toggles outside the ack cycle, so stale data never matches
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pending_r <= 1'b0;
      pm_ack <= 1'b0;
      pm_rdata <= 24'h000000;
      seen_count <= 16'h0000;
    end else begin
      pm_ack <= 1'b0;
      pm_rdata <= ~pm_rdata;
      if (pm_en) begin
        seen_addr <= pm_addr;
        seen_wdata <= pm_wdata;
        seen_wmask <= pm_wmask;
        seen_we <= pm_we;
        seen_cfg <= pm_cfg_space;
        seen_count <= seen_count + 16'h0001;
        pending_r <= 1'b1;
        wait_r <= ack_delay;
      end else if (pending_r && wait_r == 3'h0) begin
        pm_ack <= 1'b1;
        pm_rdata <= word_at(seen_addr);
        pending_r <= 1'b0;
      end else if (pending_r) begin
        wait_r <= wait_r - 3'h1;
      end
    end
  end
endmodule

// >>> tb_program_space_table_access.sv
// Testbench for the table access unit: random and corner table operations.
// Assumes the unit's package and a program memory model that echoes accesses.
module tb_program_space_table_access;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, reset = 1'b1, tbl_start = 1'b0, tbl_byte_mode = 1'b0;
  logic [1:0] tbl_op = 2'h0;
  logic [15:0] tbl_ea = 16'h0000, tbl_wdata = 16'h0000, tbl_rdata, seen_count;
  logic tbl_busy, tbl_done, pm_en, pm_we, pm_cfg_space, pm_ack, seen_we, seen_cfg;
  logic [23:0] pm_addr, pm_wdata, pm_rdata, seen_addr, seen_wdata;
  logic [2:0] pm_wmask, seen_wmask, mem_delay = 3'h0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h00000000, avs_readdata, q, r;
  logic [7:0] page_v = 8'h00;
  integer seed = 32'h12303c69;
  int err_count = 0, tests_run = 0, ops = 0;

  always #2 sys_clk = ~sys_clk;

  table_access_unit DUT (.sys_clk(sys_clk), .reset(reset), .tbl_start(tbl_start), .tbl_op(tbl_op),
    .tbl_byte_mode(tbl_byte_mode), .tbl_ea(tbl_ea), .tbl_wdata(tbl_wdata), .tbl_busy(tbl_busy),
    .tbl_done(tbl_done), .tbl_rdata(tbl_rdata), .pm_en(pm_en), .pm_we(pm_we), .pm_cfg_space(pm_cfg_space),
    .pm_addr(pm_addr), .pm_wdata(pm_wdata), .pm_wmask(pm_wmask), .pm_rdata(pm_rdata), .pm_ack(pm_ack),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  program_memory_model mem (.sys_clk(sys_clk), .reset(reset), .pm_en(pm_en), .pm_we(pm_we),
    .pm_cfg_space(pm_cfg_space), .pm_addr(pm_addr), .pm_wdata(pm_wdata), .pm_wmask(pm_wmask),
    .ack_delay(mem_delay), .pm_rdata(pm_rdata), .pm_ack(pm_ack), .seen_addr(seen_addr),
    .seen_wdata(seen_wdata), .seen_wmask(seen_wmask), .seen_we(seen_we), .seen_cfg(seen_cfg),
    .seen_count(seen_count));

  // ----------------------------------------------------------------
  // Expected values
  // ----------------------------------------------------------------
  function automatic logic [23:0] word_at(input logic [23:0] a);
    return {a[7:0] ^ a[23:16], a[15:0] ^ 16'h3c5a};
  endfunction
  function automatic logic [15:0] exp_read(input logic [1:0] op, input logic bm, input logic sel,
                                           input logic [23:0] pw);
    if (!op[0]) return bm ? {8'h00, sel ? pw[15:8] : pw[7:0]} : pw[15:0];
    return (bm && sel) ? 16'h0000 : {8'h00, pw[23:16]};
  endfunction
  function automatic logic [2:0] exp_mask(input logic [1:0] op, input logic bm, input logic sel);
    if (!op[0]) return bm ? (sel ? 3'h2 : 3'h1) : 3'h3;
    return (bm && sel) ? 3'h0 : 3'h4;
  endfunction
  // Low-space byte writes land on both low lanes; the mask picks the live one
  function automatic logic [23:0] exp_wdata(input logic [1:0] op, input logic bm, input logic [15:0] wd);
    if (op[0]) return {wd[7:0], 16'h0000};
    return bm ? {8'h00, wd[7:0], wd[7:0]} : {8'h00, wd};
  endfunction
  function automatic logic [23:0] lanes(input logic [2:0] m);
    return {{8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction

  // ----------------------------------------------------------------
  // Compare, bus and operation tasks
  // ----------------------------------------------------------------
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Avalon access: request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    avs_read <= !wr;
    avs_write <= wr;
    // No cycle limit here: only the watchdog may end a stalled answer
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic set_page(input logic [7:0] p);
    bus(1'b1, table_access_pkg::OFS_TABLE_PAGE, {24'h000000, p}, q);
    page_v = p;
    bus(1'b0, table_access_pkg::OFS_TABLE_PAGE, 32'h00000000, q);
    check_val(q, {24'h000000, p});
  endtask

  // One table operation; start is dropped at the edge that sees done
  task automatic do_op(input logic [1:0] op, input logic bm, input logic [15:0] ea, input logic [15:0] wd);
    logic [23:0] a;
    logic [15:0] c0;
    int n = 0;
    a = {page_v, ea[15:1], 1'b0};
    c0 = seen_count;
    r = $random(seed);
    @(posedge sys_clk);
    tbl_start <= 1'b1;
    tbl_op <= op;
    tbl_byte_mode <= bm;
    tbl_ea <= ea;
    tbl_wdata <= wd;
    mem_delay <= r[2:0];
    do begin
      @(posedge sys_clk);
      n++;
    end while (tbl_done !== 1'b1 && n < 60);
    tbl_start <= 1'b0;
    if (n >= 60) err_count++;
    ops++;
    check_val({31'h0, tbl_busy}, 32'h1);
    check_val({16'h0000, seen_count - c0}, 32'h1);
    check_val({8'h00, seen_addr}, {8'h00, a});
    check_val({31'h0, seen_cfg}, {31'h0, page_v[7]});
    check_val({31'h0, seen_we}, {31'h0, op[1]});
    if (op[1]) begin
      check_val({29'h0, seen_wmask}, {29'h0, exp_mask(op, bm, ea[0])});
      check_val({8'h00, seen_wdata & lanes(seen_wmask)}, {8'h00, exp_wdata(op, bm, wd) & lanes(seen_wmask)});
    end else begin
      check_val({16'h0000, tbl_rdata}, {16'h0000, exp_read(op, bm, ea[0], word_at(a))});
    end
    bus(1'b0, table_access_pkg::OFS_LAST_ADDR, 32'h00000000, q);
    check_val(q, {8'h00, page_v, ea});
    bus(1'b0, table_access_pkg::OFS_STATUS, 32'h00000000, q);
    check_val(q, {27'h0, bm, op, page_v[7], 1'b0});
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence: reset, registers, corner table, random traffic
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    check_val({28'h0, tbl_busy, tbl_done, pm_en, avs_waitrequest}, 32'h1);
    bus(1'b0, table_access_pkg::OFS_TABLE_PAGE, 32'h00000000, q);
    check_val(q, 32'h00000000);
    bus(1'b1, 4'h2, 32'hffffffff, q);
    bus(1'b0, 4'h2, 32'h00000000, q);
    check_val(q, 32'h00000000);
    bus(1'b1, table_access_pkg::OFS_STATUS, 32'hffffffff, q);
    bus(1'b0, table_access_pkg::OFS_STATUS, 32'h00000000, q);
    check_val(q, 32'h00000000);
    // Every op, mode and byte select, in user and configuration pages
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      set_page(i[0] ? {i[1], 7'h7f} : {i[1], 7'h00});
      for (int k = 0; k < 8; k++) begin
        r = $random(seed);
        do_op(k[2:1], k[0], {r[15:1], k[2]}, r[31:16]);
        do_op(k[2:1], k[0], {r[15:1], ~k[2]}, r[31:16]);
      end
    end
    // Random traffic with a changing page
    for (int k = 0; k < 40; k++) begin
      r = $random(seed);
      if (k % 8 == 0) set_page(r[31:24]);
      r = $random(seed);
      do_op(r[1:0], r[2], r[31:16], r[15:0]);
    end
    bus(1'b0, table_access_pkg::OFS_OP_COUNT, 32'h00000000, q);
    check_val(q, ops);
    wrap_up();
  end

  // Hang guard: the whole run needs well under 10000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    wrap_up();
  end
endmodule
